// ===== ccox_exec.sv
`timescale 1ns/10ps
module ccox_exec
  import ccox_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  // Instruction issue
  input  wire logic        INSN_VALID_I,
  input  wire logic [13:0] INSN_I,
  // File register read data for the addressed operand
  input  wire logic [7:0]  FILE_RD_DATA_I,
  // File register write port
  output logic             FILE_WR_EN_O,
  output logic [6:0]       FILE_ADDR_O,
  output logic [7:0]       FILE_WR_DATA_O,
  // Accumulator
  output logic [7:0]       ACC_O,
  // Status flags
  output logic             ZERO_FLAG_O,
  output logic             ZERO_FLAG_WE_O,
  output logic             EXPIRY_FLAG_N_O,
  output logic             SLEEP_ENTRY_FLAG_N_O,
  output logic             FLAGS_WE_O,
  // Watchdog control
  output logic             WDG_CLEAR_O,
  output logic             WDG_PRESCALE_CLEAR_O,
  // Completion
  output logic             DONE_O
);

  ////////////////////////////////////////////////////////////////////////
  // Decoded class and operand
  ccox_op_e   op;
  logic       go;
  logic       dest;
  logic [7:0] inv_val;
  logic       inv_is_zero;

  // One strobe per executed operation
  logic       do_clr_file;
  logic       do_clr_acc;
  logic       do_inv_acc;
  logic       do_inv_file;
  logic       do_kick;
  logic       do_any;

  // Next values of the output registers
  logic       wr_en_nxt;
  logic [6:0] addr_nxt;
  logic [7:0] wr_data_nxt;
  logic [7:0] acc_nxt;
  logic       zero_nxt;
  logic       zero_we_nxt;
  logic       expiry_n_nxt;
  logic       sleep_n_nxt;
  logic       flags_we_nxt;
  logic       wdg_clr_nxt;
  logic       pre_clr_nxt;
  logic       done_nxt;

  ccox_decode u_dec (
    .insn_i (INSN_I),
    .op_o   (op)
  );

  // A frozen cycle takes nothing
  assign go          = CE_I & INSN_VALID_I;
  assign dest        = INSN_I[DEST_BIT];
  // Operand arrives combinationally beside its word
  assign inv_val     = ~FILE_RD_DATA_I;
  assign inv_is_zero = (inv_val == ZERO_BYTE);

  ////////////////////////////////////////////////////////////////////////
  // Operation strobes; an unknown word leaves them all low
  // Qualified once here so every path below except the write address sees one source
  always_comb begin
    do_clr_file = 1'b0;
    do_clr_acc  = 1'b0;
    do_inv_acc  = 1'b0;
    do_inv_file = 1'b0;
    do_kick     = 1'b0;
    if (go) begin
      case (op)
        CCOX_CLEAR_FILE_REG_OP: begin
          do_clr_file = 1'b1;
        end
        CCOX_CLRA: begin
          do_clr_acc = 1'b1;
        end
        // Destination bit picks accumulator or file
        CCOX_INV: begin
          do_inv_acc  = !dest;
          do_inv_file = dest;
        end
        CCOX_KICK: begin
          do_kick = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  assign do_any = do_clr_file | do_clr_acc | do_inv_acc | do_inv_file | do_kick;

  ////////////////////////////////////////////////////////////////////////
  // File register write path; words not ours leave it alone
  always_comb begin
    wr_en_nxt   = 1'b0;
    // Address tracks every enabled word; harmless without a strobe
    addr_nxt    = INSN_I[ADDR_W-1:0];
    wr_data_nxt = FILE_WR_DATA_O;
    if (do_clr_file) begin
      wr_en_nxt   = 1'b1;
      wr_data_nxt = ZERO_BYTE;
    end else if (do_inv_file) begin
      wr_en_nxt   = 1'b1;
      wr_data_nxt = inv_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator
  always_comb begin
    acc_nxt = ACC_O;
    if (do_clr_acc) begin
      acc_nxt = ZERO_BYTE;
    end else if (do_inv_acc) begin
      acc_nxt = inv_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Zero flag; held until a later op rewrites it
  // Write enable lets the status word merge other flag sources
  always_comb begin
    zero_nxt    = ZERO_FLAG_O;
    zero_we_nxt = 1'b0;
    if (do_clr_file) begin
      zero_nxt    = 1'b1;
      zero_we_nxt = 1'b1;
    end else if (do_clr_acc) begin
      zero_nxt    = 1'b1;
      zero_we_nxt = 1'b1;
    end else if (do_inv_acc || do_inv_file) begin
      zero_nxt    = inv_is_zero;
      zero_we_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog kick and its status flags
  // Lowering the two flags belongs to timeout and sleep logic
  always_comb begin
    wdg_clr_nxt  = do_kick;
    pre_clr_nxt  = do_kick;
    flags_we_nxt = do_kick;
    expiry_n_nxt = EXPIRY_FLAG_N_O;
    sleep_n_nxt  = SLEEP_ENTRY_FLAG_N_O;
    if (do_kick) begin
      expiry_n_nxt = 1'b1;
      sleep_n_nxt  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Single-cycle completion, so no stall path exists
  always_comb begin
    done_nxt = do_any;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; a low enable freezes every one of them
  // Pulses last one enabled cycle, so a frozen cycle stretches them
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      FILE_WR_EN_O <= 1'b0;
    end else if (CE_I) begin
      FILE_WR_EN_O <= wr_en_nxt;
    end
  end

  // Write address
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      FILE_ADDR_O <= ADDR_RST;
    end else if (CE_I) begin
      FILE_ADDR_O <= addr_nxt;
    end
  end

  // Write data
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      FILE_WR_DATA_O <= ZERO_BYTE;
    end else if (CE_I) begin
      FILE_WR_DATA_O <= wr_data_nxt;
    end
  end

  // Accumulator register
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ACC_O <= ACC_RST;
    end else if (CE_I) begin
      ACC_O <= acc_nxt;
    end
  end

  // Zero flag value
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ZERO_FLAG_O <= 1'b0;
    end else if (CE_I) begin
      ZERO_FLAG_O <= zero_nxt;
    end
  end

  // Zero flag write pulse
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ZERO_FLAG_WE_O <= 1'b0;
    end else if (CE_I) begin
      ZERO_FLAG_WE_O <= zero_we_nxt;
    end
  end

  // Expiry flag, active low
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      EXPIRY_FLAG_N_O <= 1'b1;
    end else if (CE_I) begin
      EXPIRY_FLAG_N_O <= expiry_n_nxt;
    end
  end

  // Sleep-entry flag, active low
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      SLEEP_ENTRY_FLAG_N_O <= 1'b1;
    end else if (CE_I) begin
      SLEEP_ENTRY_FLAG_N_O <= sleep_n_nxt;
    end
  end

  // Status flag write pulse
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      FLAGS_WE_O <= 1'b0;
    end else if (CE_I) begin
      FLAGS_WE_O <= flags_we_nxt;
    end
  end

  // Watchdog counter clear
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      WDG_CLEAR_O <= 1'b0;
    end else if (CE_I) begin
      WDG_CLEAR_O <= wdg_clr_nxt;
    end
  end

  // Watchdog prescaler clear
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      WDG_PRESCALE_CLEAR_O <= 1'b0;
    end else if (CE_I) begin
      WDG_PRESCALE_CLEAR_O <= pre_clr_nxt;
    end
  end

  // Completion pulse
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      DONE_O <= 1'b0;
    end else if (CE_I) begin
      DONE_O <= done_nxt;
    end
  end

endmodule : ccox_exec

// ===== ccox_pkg.sv
package ccox_pkg;
  // Instruction word layout
  localparam int unsigned INSN_W   = 14;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned DEST_BIT = 7;

  // Fixed encodings and match masks
  localparam logic [13:0] CLR_FILE_PAT  = 14'h0180;
  localparam logic [13:0] CLR_FILE_MASK = 14'h3F80;
  localparam logic [13:0] CLR_ACC_PAT   = 14'h0103;
  localparam logic [13:0] INV_FILE_PAT  = 14'h0900;
  localparam logic [13:0] INV_FILE_MASK = 14'h3F00;
  localparam logic [13:0] WDG_KICK_PAT  = 14'h0064;
  localparam logic [13:0] FULL_MASK     = 14'h3FFF;

  // Reset and constant values
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam logic [6:0]  ADDR_RST      = 7'h00;

  typedef enum logic [4:0] {
    CCOX_NONE  = 5'b00001,
    CCOX_CLEAR_FILE_REG_OP  = 5'b00010,
    CCOX_CLRA  = 5'b00100,
    CCOX_INV   = 5'b01000,
    CCOX_KICK  = 5'b10000
  } ccox_op_e;
endpackage : ccox_pkg

// ===== ccox_decode.sv
`timescale 1ns/10ps
module ccox_decode
  import ccox_pkg::*;
(
  // Instruction
  input  wire logic [13:0] insn_i,
  // Decoded class
  output ccox_op_e         op_o
);
  always_comb begin
    if ((insn_i & CLR_FILE_MASK) == CLR_FILE_PAT) begin
      op_o = CCOX_CLEAR_FILE_REG_OP;
    end else if ((insn_i & FULL_MASK) == CLR_ACC_PAT) begin
      op_o = CCOX_CLRA;
    end else if ((insn_i & INV_FILE_MASK) == INV_FILE_PAT) begin
      op_o = CCOX_INV;
    end else if ((insn_i & FULL_MASK) == WDG_KICK_PAT) begin
      op_o = CCOX_KICK;
    end else begin
      op_o = CCOX_NONE;
    end
  end
endmodule : ccox_decode

// ===== ccox_checker.sv
`timescale 1ns/10ps
module ccox_checker (
  // Watched ports
  input wire logic        SYS_CLK_I, RST_I, CE_I, INSN_VALID_I,
  input wire logic [13:0] INSN_I,
  input wire logic [7:0]  FILE_RD_DATA_I, FILE_WR_DATA_O, ACC_O,
  input wire logic [6:0]  FILE_ADDR_O,
  input wire logic        FILE_WR_EN_O, ZERO_FLAG_O, ZERO_FLAG_WE_O, DONE_O,
  input wire logic        EXPIRY_FLAG_N_O, SLEEP_ENTRY_FLAG_N_O, FLAGS_WE_O,
  input wire logic        WDG_CLEAR_O, WDG_PRESCALE_CLEAR_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  wire t = CE_I && INSN_VALID_I;
  clr_file_a: assert property (t && (INSN_I & 14'h3F80) == 14'h0180 |=>
    FILE_WR_EN_O && FILE_WR_DATA_O == 8'h00 && ZERO_FLAG_O
    && FILE_ADDR_O == $past(INSN_I[6:0])) else $error("clear file wrong");
  clr_acc_a: assert property (t && INSN_I == 14'h0103 |=>
    ACC_O == 8'h00 && ZERO_FLAG_O && !FILE_WR_EN_O) else $error("clear acc wrong");
  inv_acc_a: assert property (t && (INSN_I & 14'h3F80) == 14'h0900 |=>
    ACC_O == ~$past(FILE_RD_DATA_I) && !FILE_WR_EN_O) else $error("invert to acc wrong");
  inv_file_a: assert property (t && (INSN_I & 14'h3F80) == 14'h0980 |=>
    FILE_WR_EN_O && FILE_WR_DATA_O == ~$past(FILE_RD_DATA_I)) else $error("invert wrong");
  wdg_clear_a: assert property (t && INSN_I == 14'h0064 |=>
    WDG_CLEAR_O && WDG_PRESCALE_CLEAR_O) else $error("watchdog not cleared");
  flags_set_a: assert property (t && INSN_I == 14'h0064 |=>
    FLAGS_WE_O && EXPIRY_FLAG_N_O && SLEEP_ENTRY_FLAG_N_O) else $error("flags not set");
  inv_zero_a: assert property (t && (INSN_I & 14'h3F00) == 14'h0900 |=> ZERO_FLAG_WE_O
    && ZERO_FLAG_O == ($past(FILE_RD_DATA_I) == 8'hFF)) else $error("zero flag wrong");
  // Idle cycle must not report completion; a frozen one holds it
  done_cause_a: assert property (CE_I && !INSN_VALID_I |=> !DONE_O)
    else $error("done without op");
  frozen_hold_a: assert property (!CE_I |=> $stable(DONE_O) && $stable(ACC_O))
    else $error("state moved while frozen");
  cover property (t && INSN_I == 14'h0064);
  cover property (t && INSN_I == 14'h0103);
  cover property (DONE_O ##1 DONE_O);
endmodule : ccox_checker
bind ccox_exec ccox_checker chk (.*);

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        SYS_CLK_I, RST_I, CE_I, INSN_VALID_I, FILE_WR_EN_O, ZERO_FLAG_O;
  logic        ZERO_FLAG_WE_O, EXPIRY_FLAG_N_O, SLEEP_ENTRY_FLAG_N_O, FLAGS_WE_O;
  logic        WDG_CLEAR_O, WDG_PRESCALE_CLEAR_O, DONE_O, z_m, wr, k, ce_q;
  logic [13:0] INSN_I, w;
  logic [7:0]  FILE_RD_DATA_I, FILE_WR_DATA_O, ACC_O, acc_m, wd_m, d;
  logic [6:0]  FILE_ADDR_O, a;
  logic [30:0] q[$];
  wire  [30:0] obs = {FILE_WR_EN_O, FILE_ADDR_O, FILE_WR_DATA_O, ACC_O, ZERO_FLAG_O,
    ZERO_FLAG_WE_O, FLAGS_WE_O, WDG_CLEAR_O, WDG_PRESCALE_CLEAR_O, EXPIRY_FLAG_N_O,
    SLEEP_ENTRY_FLAG_N_O};
  int          err_count, n_checks, seed, i, op;
  ccox_exec dut (.*);
  initial begin
    SYS_CLK_I = 1'b0;
    forever #10 SYS_CLK_I = ~SYS_CLK_I;
  end
  task chk(input string nm, input logic [30:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  // Oldest note against each completion
  // Held outputs of a frozen cycle are no fresh completion
  always @(posedge SYS_CLK_I) begin
    ce_q <= CE_I;
    if (DONE_O === 1'b1 && ce_q === 1'b1) begin
      if (q.size() == 0) chk("done", 31'h1, 31'h0);
      else chk("outputs", obs, q.pop_front());
    end
  end
  initial begin
    #20000;
    err_count++;
    results;
  end
  initial begin
    seed = 32'h54E08470;
    {RST_I, CE_I, INSN_VALID_I, INSN_I, FILE_RD_DATA_I} = {2'b11, 23'h0};
    {acc_m, wd_m, z_m} = 17'h0;
    repeat (16) @(posedge SYS_CLK_I);
    chk("reset", obs, 31'h3);
    chk("reset done", 31'(DONE_O), 31'h0);
    RST_I <= 1'b0;
    // Back to back, with refused and frozen cycles mixed in
    for (i = 0; i < 200; i++) begin
      @(posedge SYS_CLK_I);
      op = $unsigned($random(seed)) % 7;
      a = $random(seed);
      d = a[2] ? 8'hFF : $random(seed);
      {wr, k} = 2'b00;
      case (op)
        0, 6: w = {7'h03, a};
        1: w = 14'h0103;
        2: w = {7'h12, a};
        3: w = {7'h13, a};
        4: w = 14'h0064;
        default: w = 14'h3FFF;
      endcase
      case (op)
        0: {wr, wd_m, z_m} = {1'b1, 8'h00, 1'b1};
        1: {acc_m, z_m} = {8'h00, 1'b1};
        2: {acc_m, z_m} = {~d, d == 8'hFF};
        3: {wr, wd_m, z_m} = {1'b1, ~d, d == 8'hFF};
        4: k = 1'b1;
        default: ;
      endcase
      if (op < 5) q.push_back({wr, w[6:0], wd_m, acc_m, z_m, op < 4, k, k, k, 2'b11});
      INSN_I <= w;
      FILE_RD_DATA_I <= d;
      INSN_VALID_I <= 1'b1;
      CE_I <= (op != 6);
    end
    @(posedge SYS_CLK_I);
    INSN_VALID_I <= 1'b0;
    repeat (3) @(posedge SYS_CLK_I);
    chk("queue", 31'(q.size()), 31'h0);
    results;
  end
endmodule : tb_top
